// ==== rtl/vcd_chan_div.sv ====
// One channel divider with duty correction, coarse phase and start level
module vcd_chan_div
   import vcd_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        tick,
   input  wire logic        in_lvl,
   input  wire logic        sync,
   input  wire vcd_ch_cfg_t cfg,
   output logic             out_a,
   output logic             out_b
);
   logic [5:0] cnt_r;
   logic [4:0] dly_r;
   logic       lvl_r;
   logic       half_r;
   logic [5:0] high_len;
   logic [5:0] low_len;
   logic       odd_fix;

   // fields are cycles minus one; lengths
   assign high_len = {2'b00, cfg.high_cnt} + 6'd1;
   assign low_len  = {2'b00, cfg.low_cnt} + 6'd1;
   // correction only when low equals high plus one
   assign odd_fix  = !cfg.dcc_off && (cfg.low_cnt == cfg.high_cnt + 4'd1);

   always_ff @(posedge aclk) begin
      if (!aresetn || sync) begin
         cnt_r  <= 6'd0;
         dly_r  <= cfg.phase;
         lvl_r  <= cfg.start_high;
         half_r <= 1'b0;
      end else begin
         if (tick) begin
            if (dly_r != 5'd0) begin
               dly_r <= dly_r - 5'd1;
            end else if (cnt_r + 6'd1 >= (lvl_r ? high_len : low_len)) begin
               cnt_r <= 6'd0;
               lvl_r <= !lvl_r;
            end else begin
               cnt_r <= cnt_r + 6'd1;
            end
         end
         // One-cycle delayed level marks only the first cycle after a fall
         half_r <= lvl_r;
      end
   end

   logic div_out;
   // Stretch high for the one aclk cycle just after the fall, if the input is still high then; clock grained
   assign div_out = cfg.bypass ? in_lvl : (lvl_r | (odd_fix & half_r & !lvl_r & in_lvl));

   always_ff @(posedge aclk) begin
      if (!aresetn || sync) begin
         out_a <= 1'b0;
         out_b <= 1'b0;
      end else begin
         out_a <= cfg.direct ? in_lvl : div_out;
         out_b <= cfg.direct ? in_lvl : div_out;
      end
   end
endmodule : vcd_chan_div

// ==== rtl/vcd_pkg.sv ====
// Package of constants and types for the calibration sequencer and distribution front end
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
package vcd_pkg;
   // Register byte addresses (printed offsets are not all multiples of four)
   localparam logic [11:0] VCD_IDX_PLLCAL  = 12'h0018;
   localparam logic [11:0] VCD_IDX_STATUS  = 12'h001F;
   localparam logic [11:0] VCD_IDX_CH0     = 12'h0190;
   localparam logic [11:0] VCD_IDX_SRC     = 12'h01E1;
   localparam logic [11:0] VCD_IDX_PRE     = 12'h01E0;
   localparam logic [11:0] VCD_IDX_UPDATE  = 12'h0232;
   localparam logic [13:0] VCD_A_PLLCAL    = {VCD_IDX_PLLCAL, 2'b00};
   localparam logic [13:0] VCD_A_STATUS    = {VCD_IDX_STATUS, 2'b00};
   localparam logic [13:0] VCD_A_CH0       = {VCD_IDX_CH0, 2'b00};
   localparam logic [13:0] VCD_A_CH1       = {VCD_IDX_CH0 + 12'h0003, 2'b00};
   localparam logic [13:0] VCD_A_CH2       = {VCD_IDX_CH0 + 12'h0006, 2'b00};
   localparam logic [13:0] VCD_A_SRC       = {VCD_IDX_SRC, 2'b00};
   localparam logic [13:0] VCD_A_PRE       = {VCD_IDX_PRE, 2'b00};
   localparam logic [13:0] VCD_A_UPDATE    = {VCD_IDX_UPDATE, 2'b00};
   localparam logic [13:0] VCD_A_RDIV      = 14'h0040;
   // Field positions
   localparam int VCD_CAL_TRIG_BIT  = 0;
   localparam int VCD_CAL_DONE_BIT  = 6;
   localparam int VCD_CAL_BUSY_BIT  = 0;
   localparam int VCD_UPD_BIT       = 0;
   // Channel word: [3:0] high, [7:4] low, [8] bypass, [9] duty off,
   // [10] direct, [11] start high, [16:12] phase
   localparam logic [31:0] VCD_CH_RST     = 32'h0000_0000;
   localparam logic [31:0] VCD_PLLCAL_RST = 32'h0000_0000;
   localparam logic [1:0]  VCD_SRC_RST    = 2'b10;
   localparam logic [2:0]  VCD_PRE_RST    = 3'h0;
   localparam logic [15:0] VCD_RDIV_RST   = 16'h0001;
   localparam logic [12:0] VCD_CAL_CYCLES = 13'h1130;          // 4400
   localparam logic [1:0]  VCD_RESP_OKAY  = 2'b00;
   localparam logic [1:0]  VCD_RESP_SLV   = 2'b10;

   typedef enum logic [1:0] {
      VCD_SRC_EXT_PRE = 2'b00,
      VCD_SRC_EXT_DIR = 2'b01,
      VCD_SRC_OSC_PRE = 2'b10,
      VCD_SRC_BAD     = 2'b11
   } vcd_src_t;

   typedef struct packed {
      logic [4:0] phase;
      logic       start_high;
      logic       direct;
      logic       dcc_off;
      logic       bypass;
      logic [3:0] low_cnt;
      logic [3:0] high_cnt;
   } vcd_ch_cfg_t;

   typedef struct packed {
      logic       trig;
      logic [1:0] cal_div;
      logic [2:0] pre_sel;
      vcd_src_t   src;
   } vcd_ctl_t;
endpackage : vcd_pkg

// ==== rtl/vcd_top.sv ====
// Calibration sequencer, distribution source select, prescaler and AXI4-Lite registers
module vcd_top
   import vcd_pkg::*;
#(
   parameter int NCH = 3
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ref_tick,
   input  wire logic        ext_clk_lvl,
   input  wire logic        osc_clk_lvl,
   input  wire logic [13:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [13:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [2*NCH-1:0] clock_output_pins,
   output logic             cal_sync
);
   //----------------------------------------------------------------------
   // Register bus
   //----------------------------------------------------------------------
   logic [13:0] aw_r;
   logic        aw_have_r;
   logic [31:0] w_r;
   logic        w_have_r;
   logic        w_lane0_r;
   logic        wr_go;
   logic        wr_hit;
   logic        upd_hit;

   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
   assign wr_go         = aw_have_r && w_have_r && !s_axi_bvalid;

   // Shadow copies written by software, live copies taken on update
   vcd_ch_cfg_t ch_sh_r [NCH];
   vcd_ch_cfg_t ch_lv_r [NCH];
   vcd_ctl_t    ctl_sh_r;
   vcd_ctl_t    ctl_lv_r;
   logic [15:0] rdiv_r;
   logic        upd_r;

   assign upd_hit = wr_go && aw_r == VCD_A_UPDATE && w_r[VCD_UPD_BIT];
   assign wr_hit  = aw_r == VCD_A_PLLCAL || aw_r == VCD_A_SRC || aw_r == VCD_A_PRE
                    || aw_r == VCD_A_UPDATE || aw_r == VCD_A_RDIV || aw_r == VCD_A_CH0
                    || aw_r == VCD_A_CH1 || aw_r == VCD_A_CH2;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r    <= 1'b0;
         w_have_r     <= 1'b0;
         aw_r         <= 14'h0000;
         w_r          <= 32'h0000_0000;
         w_lane0_r    <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= VCD_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_r      <= s_axi_awaddr;
            aw_have_r <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_r      <= s_axi_wdata;
            w_lane0_r <= s_axi_wstrb[0];
            w_have_r <= 1'b1;
         end
         if (wr_go) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? VCD_RESP_OKAY : VCD_RESP_SLV;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Byte strobe 0 alone gates every write except the update trigger, wider fields included; the other lanes are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_sh_r <= '{trig: 1'b0, cal_div: 2'b00, pre_sel: VCD_PRE_RST, src: VCD_SRC_OSC_PRE};
         rdiv_r   <= VCD_RDIV_RST;
         for (int i = 0; i < NCH; i++) begin
            ch_sh_r[i] <= vcd_ch_cfg_t'(VCD_CH_RST[16:0]);
         end
      end else if (wr_go && w_lane0_r) begin
         unique case (aw_r)
            VCD_A_PLLCAL: begin
               ctl_sh_r.trig    <= w_r[VCD_CAL_TRIG_BIT];
               ctl_sh_r.cal_div <= w_r[2:1];
            end
            VCD_A_PRE: ctl_sh_r.pre_sel <= w_r[2:0];
            VCD_A_SRC: begin
               if (w_r[1:0] != VCD_SRC_BAD) begin
                  ctl_sh_r.src <= vcd_src_t'(w_r[1:0]);
               end
            end
            VCD_A_RDIV: rdiv_r <= w_r[15:0];
            VCD_A_CH0: ch_sh_r[0] <= vcd_ch_cfg_t'(w_r[16:0]);
            VCD_A_CH1: ch_sh_r[1] <= vcd_ch_cfg_t'(w_r[16:0]);
            VCD_A_CH2: ch_sh_r[2] <= vcd_ch_cfg_t'(w_r[16:0]);
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_lv_r <= '{trig: 1'b0, cal_div: 2'b00, pre_sel: VCD_PRE_RST, src: VCD_SRC_OSC_PRE};
         upd_r    <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            ch_lv_r[i] <= vcd_ch_cfg_t'(VCD_CH_RST[16:0]);
         end
      end else begin
         upd_r <= upd_hit;
         if (upd_hit) begin
            ctl_lv_r <= ctl_sh_r;
            ch_lv_r  <= ch_sh_r;
         end
      end
   end

   //----------------------------------------------------------------------
   // Calibration sequencer
   //----------------------------------------------------------------------
   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} vcd_cal_st_t;
   vcd_cal_st_t cal_st_r;
   logic        trig_old_r;
   logic        cal_start;
   logic [15:0] rcnt_r;
   logic [3:0]  ccnt_r;
   logic        pfd_tick;
   logic        cal_tick;
   logic [4:0]  cal_div_n;
   logic [12:0] cyc_r;
   logic        done_r;

   // Only a zero-to-one trigger transition armed by an update starts a run
   assign cal_start = upd_r && ctl_lv_r.trig && !trig_old_r;
   assign pfd_tick  = ref_tick && (rcnt_r + 16'd1 >= rdiv_r);
   assign cal_div_n = 5'd2 << ctl_lv_r.cal_div;
   assign cal_tick  = pfd_tick && ({1'b0, ccnt_r} + 5'd1 >= cal_div_n);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_old_r <= 1'b0;
         rcnt_r     <= 16'h0000;
         ccnt_r     <= 4'h0;
      end else begin
         if (upd_r) begin
            trig_old_r <= ctl_lv_r.trig;
         end
         // Restart both dividers so every run lasts exactly the full count
         if (cal_start) begin
            rcnt_r <= 16'h0000;
            ccnt_r <= 4'h0;
         end else begin
            if (ref_tick) begin
               rcnt_r <= pfd_tick ? 16'h0000 : rcnt_r + 16'd1;
            end
            if (pfd_tick) begin
               ccnt_r <= cal_tick ? 4'h0 : ccnt_r + 4'd1;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cal_st_r <= CAL_IDLE;
         cyc_r    <= 13'h0000;
         done_r   <= 1'b0;
      end else begin
         unique case (cal_st_r)
            CAL_IDLE, CAL_DONE: begin
               if (cal_start) begin
                  cal_st_r <= CAL_RUN;
                  cyc_r    <= 13'h0000;
                  done_r   <= 1'b0;
               end
            end
            CAL_RUN: begin
               if (cal_tick) begin
                  if (cyc_r + 13'd1 == VCD_CAL_CYCLES) begin
                     cal_st_r <= CAL_DONE;
                     done_r   <= 1'b1;
                  end
                  cyc_r <= cyc_r + 13'd1;
               end
            end
         endcase
      end
   end

   assign cal_sync = cal_st_r == CAL_RUN;

   //----------------------------------------------------------------------
   // Source select and prescaler
   //----------------------------------------------------------------------
   logic       pre_src_lvl;
   logic       pre_lvl_r;
   logic [2:0] pcnt_r;
   logic [2:0] pre_div;
   logic [2:0] pcnt_nxt;
   logic [2:0] pre_half;
   logic       ch_in_lvl;
   logic       src_lvl_r;
   logic       pre_edge;

   assign pre_div     = (ctl_lv_r.pre_sel > 3'd4) ? 3'd6 : ctl_lv_r.pre_sel + 3'd2;
   assign pre_src_lvl = (ctl_lv_r.src == VCD_SRC_OSC_PRE) ? osc_clk_lvl : ext_clk_lvl;
   assign pre_edge    = pre_src_lvl && !src_lvl_r;
   assign pcnt_nxt    = (pcnt_r + 3'd1 >= pre_div) ? 3'h0 : pcnt_r + 3'd1;
   assign pre_half    = (pre_div + 3'd1) >> 1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_lvl_r <= 1'b0;
         pcnt_r    <= 3'h0;
         pre_lvl_r <= 1'b0;
      end else begin
         src_lvl_r <= pre_src_lvl;
         if (pre_edge) begin
            pcnt_r    <= pcnt_nxt;
            // Level follows the wrapped count so divide-by-two still toggles
            pre_lvl_r <= pcnt_nxt < pre_half;
         end
      end
   end

   // Prescaled path, or raw external clock on the direct setting
   assign ch_in_lvl = (ctl_lv_r.src == VCD_SRC_EXT_DIR) ? ext_clk_lvl : pre_lvl_r;

   logic ch_lvl_r;
   logic ch_tick;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ch_lvl_r <= 1'b0;
      end else begin
         ch_lvl_r <= ch_in_lvl;
      end
   end
   assign ch_tick = ch_in_lvl && !ch_lvl_r;

   //----------------------------------------------------------------------
   // Channels
   //----------------------------------------------------------------------
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      vcd_chan_div u_div (
         .aclk    (aclk),
         .aresetn (aresetn),
         .tick    (ch_tick),
         .in_lvl  (ch_lv_r[g].direct ? pre_src_lvl : ch_in_lvl),
         .sync    (cal_sync),
         .cfg     (ch_lv_r[g]),
         .out_a   (clock_output_pins[2*g]),
         .out_b   (clock_output_pins[2*g+1])
      );
   end

   //----------------------------------------------------------------------
   // Read channel
   //----------------------------------------------------------------------
   logic [31:0] rd_val;
   logic        rd_hit;
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      unique case (s_axi_araddr)
         VCD_A_PLLCAL: rd_val = {29'h0, ctl_sh_r.cal_div, ctl_sh_r.trig};
         VCD_A_STATUS: rd_val = {25'h0, done_r, 5'h0, cal_sync};
         VCD_A_PRE:    rd_val = {29'h0, ctl_sh_r.pre_sel};
         VCD_A_SRC:    rd_val = {30'h0, ctl_sh_r.src};
         VCD_A_RDIV:   rd_val = {16'h0, rdiv_r};
         VCD_A_CH0:    rd_val = {15'h0, ch_sh_r[0]};
         VCD_A_CH1:    rd_val = {15'h0, ch_sh_r[1]};
         VCD_A_CH2:    rd_val = {15'h0, ch_sh_r[2]};
         VCD_A_UPDATE: rd_val = 32'h0000_0000;
         default:      rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= VCD_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_hit ? VCD_RESP_OKAY : VCD_RESP_SLV;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   //----------------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------------
   sequence cal_begin_s;
      cal_start && cal_st_r != CAL_RUN;
   endsequence
   sequence cal_enter_s;
      cal_st_r == CAL_RUN && !done_r;
   endsequence

   cal_start_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cal_begin_s |=> cal_enter_s) else $error("calibration did not start");
   no_auto_cal_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(cal_sync) |-> $past(cal_start)) else $error("calibration started unasked");
   done_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(cal_sync) |-> done_r) else $error("done not set at end");
   sync_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cal_sync |-> !done_r) else $error("sync overlaps done");
   cal_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (cal_sync && cal_tick && cyc_r == VCD_CAL_CYCLES - 13'd1) |=> !cal_sync && done_r)
      else $error("calibration length wrong");
   cal_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cal_tick |-> pfd_tick && {1'b0, ccnt_r} == cal_div_n - 5'd1) else $error("cal divisor wrong");
   upd_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
      upd_hit |=> ctl_lv_r == $past(ctl_sh_r)) else $error("update not applied");
   no_bad_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ctl_lv_r.src != VCD_SRC_BAD) else $error("illegal source code");
   pre_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pre_div >= 3'd2 && pre_div <= 3'd6) else $error("prescaler out of range");
   outs_static_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cal_sync ##1 cal_sync |-> clock_output_pins == '0) else $error("outputs toggled in sync");
endmodule : vcd_top

// ==== tb/testbench.sv ====
// Self-checking bench for the calibration sequencer and distribution front end
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
$display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench
   import vcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0]  r;
   } vcd_exp_t;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [13:0] awaddr = '0;
   logic [13:0] araddr = '0;
   logic [31:0] wdata = '0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [3:0]  wstrb = 4'hf;
   wire logic   ref_tick, ext_lvl, osc_lvl, awready, wready, bvalid, arready, rvalid;
   wire logic   cal_sync;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [5:0]  pins;
   int          error_cnt = 0;
   int          n_tests = 0;
   int          cal_len = 0;
   int          seed = 32'h47bb_7d8b;
   int          per, hi, n, m, hck;
   vcd_exp_t    exp_q[$];
   vcd_exp_t    e;
   vcd_ch_cfg_t cfg;

   always #2.5 aclk = ~aclk;
   always @(negedge aclk) if (cal_sync === 1'b1) cal_len++;

   vcd_ref_model u_ref (.aclk(aclk), .aresetn(aresetn), .ref_tick(ref_tick),
      .ext_clk_lvl(ext_lvl), .osc_clk_lvl(osc_lvl));
   vcd_top u_dut (.aclk(aclk), .aresetn(aresetn), .ref_tick(ref_tick), .ext_clk_lvl(ext_lvl),
      .osc_clk_lvl(osc_lvl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .clock_output_pins(pins), .cal_sync(cal_sync));

   //----------------------------------------------------------------------
   // Read result watcher
   //----------------------------------------------------------------------
   always @(negedge aclk) begin
      if (rvalid === 1'b1 && rready) begin
         e = exp_q.pop_front();
         `CHK(rdata & e.m, e.d);
         `CHK(rresp, e.r);
      end
   end

   task close_out;
      if (error_cnt == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   task tmo;
      error_cnt++;
      close_out();
   endtask : tmo

   // Ready levels are taken at the falling edge, where they are settled
   task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      logic at, wt, bt;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 1000; i++) begin
         @(negedge aclk);
         at = awvalid && awready;
         wt = wvalid && wready;
         bt = bvalid;
         if (bt) `CHK(bresp, er);
         @(posedge aclk);
         if (at) awvalid <= 1'b0;
         if (wt) wvalid <= 1'b0;
         if (bt) begin
            bready <= 1'b0;
            break;
         end
      end
      if (i == 1000) tmo();
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [31:0] d, input logic [31:0] mk,
                     input logic [1:0] er);
      int i;
      logic at, rt;
      exp_q.push_back('{d, mk, er});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 1000; i++) begin
         @(negedge aclk);
         at = arvalid && arready;
         rt = rvalid;
         @(posedge aclk);
         if (at) arvalid <= 1'b0;
         if (rt) begin
            rready <= 1'b0;
            break;
         end
      end
      if (i == 1000) tmo();
   endtask : rd

   task automatic upd;
      wr(VCD_A_UPDATE, 32'h0000_0001, VCD_RESP_OKAY);
   endtask : upd

   // Counts source rises over one whole output period, skipping the first
   task automatic meas(input int ch, input bit osc, output int p_n, output int h_n);
      int i, k;
      logic s, sp, p, pp;
      p_n = 0;
      h_n = 0;
      hck = 0;
      k = 0;
      @(negedge aclk);
      sp = osc ? osc_lvl : ext_lvl;
      pp = pins[2*ch];
      for (i = 0; i < 6000 && k < 3; i++) begin
         @(negedge aclk);
         s = osc ? osc_lvl : ext_lvl;
         p = pins[2*ch];
         if (p && !pp) k++;
         if (k == 2 && p) hck++;
         if (s && !sp && k == 2) begin
            p_n++;
            if (p) h_n++;
         end
         sp = s;
         pp = p;
      end
      if (k < 3) tmo();
   endtask : meas

   task automatic cal_go(input logic [31:0] w, input int exp);
      int i;
      cal_len = 0;
      wr(VCD_A_PLLCAL, w, VCD_RESP_OKAY);
      upd();
      for (i = 0; i < 50 && cal_sync !== 1'b1; i++) @(negedge aclk);
      rd(VCD_A_STATUS, 32'h0000_0001, 32'h0000_0041, VCD_RESP_OKAY);
      `CHK(pins, 6'h00);
      for (i = 0; i < 40000 && cal_sync !== 1'b0; i++) @(negedge aclk);
      `CHK((cal_len >= exp - 2) && (cal_len <= exp + 2), 1'b1);
      rd(VCD_A_STATUS, 32'h0000_0040, 32'h0000_0041, VCD_RESP_OKAY);
   endtask : cal_go

   //----------------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(VCD_A_STATUS, 32'h0000_0000, 32'h0000_0041, VCD_RESP_OKAY);
      rd(VCD_A_SRC, 32'h0000_0002, 32'h0000_0003, VCD_RESP_OKAY);
      rd(14'h0004, 32'h0000_0000, 32'h0000_0000, VCD_RESP_SLV);
      wr(14'h0004, 32'hffff_ffff, VCD_RESP_SLV);
      wr(VCD_A_RDIV, 32'h0000_0001, VCD_RESP_OKAY);
      wr(VCD_A_PLLCAL, 32'h0000_0001, VCD_RESP_OKAY);
      repeat (20) @(negedge aclk);
      `CHK(cal_sync, 1'b0);
      cal_go(32'h0000_0001, 8800);
      cal_len = 0;
      wr(VCD_A_CH0, 32'h0000_0011, VCD_RESP_OKAY);
      upd();
      wr(VCD_A_PLLCAL, 32'h0000_0001, VCD_RESP_OKAY);
      upd();
      repeat (50) @(negedge aclk);
      `CHK(cal_len, 0);
      wr(VCD_A_PLLCAL, 32'h0000_0000, VCD_RESP_OKAY);
      upd();
      cal_go(32'h0000_0003, 17600);
      wr(VCD_A_SRC, 32'h0000_0001, VCD_RESP_OKAY);
      for (int j = 0; j < 3; j++) begin
         n = $random(seed) & 15;
         m = $random(seed) & 15;
         cfg = '0;
         cfg.high_cnt = n[3:0];
         cfg.low_cnt = m[3:0];
         cfg.dcc_off = 1'b1;
         wr(VCD_A_CH0 + 14'(12*j), 32'(cfg), VCD_RESP_OKAY);
         upd();
         meas(j, 1'b0, per, hi);
         `CHK(per, n + m + 2);
         `CHK(hi, n + 1);
      end
      cfg.bypass = 1'b1;
      wr(VCD_A_CH0 + 14'(24), 32'(cfg), VCD_RESP_OKAY);
      meas(2, 1'b0, per, hi);
      `CHK(per, n + m + 2);
      upd();
      meas(2, 1'b0, per, hi);
      `CHK(per, 1);
      // Duty correction on channel 0: odd division with low one longer than high
      n = $random(seed) & 7;
      wr(VCD_A_CH0, 32'(n) | (32'(n + 1) << 4), VCD_RESP_OKAY);
      upd();
      meas(0, 1'b0, per, hi);
      `CHK(per, 2 * n + 3);
      `CHK((2 * hck >= 4 * per - 2) && (2 * hck <= 4 * per + 2), 1'b1);
      // Prescaler path from the external clock; pre code k divides by k plus two
      wr(VCD_A_SRC, 32'h0000_0000, VCD_RESP_OKAY);
      for (int k = 0; k < 5; k++) begin
         wr(VCD_A_PRE, 32'(k), VCD_RESP_OKAY);
         upd();
         meas(2, 1'b0, per, hi);
         `CHK(per, k + 2);
      end
      wr(VCD_A_SRC, 32'h0000_0002, VCD_RESP_OKAY);
      wr(VCD_A_PRE, 32'h0000_0001, VCD_RESP_OKAY);
      upd();
      meas(2, 1'b1, per, hi);
      `CHK(per, 3);
      wr(VCD_A_SRC, 32'h0000_0003, VCD_RESP_OKAY);
      upd();
      rd(VCD_A_SRC, 32'h0000_0002, 32'h0000_0003, VCD_RESP_OKAY);
      meas(2, 1'b1, per, hi);
      `CHK(per, 3);
      wstrb <= 4'h0;
      wr(VCD_A_SRC, 32'h0000_0001, VCD_RESP_OKAY);
      wstrb <= 4'hf;
      rd(VCD_A_SRC, 32'h0000_0002, 32'h0000_0003, VCD_RESP_OKAY);
      wr(VCD_A_SRC, 32'h0000_0000, VCD_RESP_OKAY);
      wr(VCD_A_PRE, 32'h0000_0002, VCD_RESP_OKAY);
      wr(VCD_A_CH0, 32'h0000_0455, VCD_RESP_OKAY);
      upd();
      meas(0, 1'b0, per, hi);
      `CHK(per, 1);
      close_out();
   end
endmodule : testbench

// ==== tb/vcd_ref_model.sv ====
// Reference tick and clock-source level model for the far side of the block
module vcd_ref_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      ref_tick,
   output logic      ext_clk_lvl,
   output logic      osc_clk_lvl
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       ce_r;
   logic [1:0] co_r;
   //----------------------------------------------------------------------
   // Sources
   //----------------------------------------------------------------------
   // Reference is always present so a calibration never stalls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_tick <= 1'b0;
         ce_r <= 1'b0;
         co_r <= 2'h0;
         ext_clk_lvl <= 1'b0;
         osc_clk_lvl <= 1'b0;
      end else begin
         ref_tick <= 1'b1;
         ce_r <= ~ce_r;
         co_r <= (co_r == 2'h2) ? 2'h0 : co_r + 2'h1;
         if (ce_r) begin
            ext_clk_lvl <= ~ext_clk_lvl;
         end
         if (co_r == 2'h0) begin
            osc_clk_lvl <= ~osc_clk_lvl;
         end
      end
   end
endmodule : vcd_ref_model
